// ===== dv/igs_sensor_model.sv
// sensor readout model: one raster frame of pixels per request
`timescale 1ns/1ps
module igs_sensor_model #(
   parameter int SW  = 8,
   parameter int SH  = 4,
   parameter int GAP = 1
) (
   // clock and frame request
   input  wire logic       clk_sys_i,
   input  wire logic       go_i,
   // pixel stream towards the stage
   output logic            pix_valid_o,
   output logic            pix_sof_o,
   output logic [7:0]      pix_data_o
);
   // pixel value encodes its position; idle cycles toggle the data so a
   // stage that samples without valid sees garbage, not a stale pixel
   initial begin
      pix_valid_o = 1'b0;
      pix_sof_o = 1'b0;
      pix_data_o = 8'h00;
      forever begin
         @(posedge clk_sys_i);
         if (go_i) begin
            for (int r = 0; r < SH; r++) begin
               for (int c = 0; c < SW; c++) begin
                  pix_valid_o <= 1'b1;
                  pix_sof_o   <= (r == 0 && c == 0);
                  pix_data_o  <= 8'((r * SW) + c);
                  @(posedge clk_sys_i);
                  for (int g = 0; g < GAP; g++) begin
                     pix_valid_o <= 1'b0;
                     pix_data_o  <= ~pix_data_o;
                     @(posedge clk_sys_i);
                  end
               end
            end
            pix_valid_o <= 1'b0;
            pix_sof_o   <= 1'b0;
         end
         pix_data_o <= ~pix_data_o;
      end
   end
endmodule // igs_sensor_model

// ===== dv/image_aoi_binning_decimation_flip_tb.sv
// self-checking bench for the image geometry stage
`timescale 1ns/1ps
`include "igs_regs.svh"
module image_aoi_binning_decimation_flip_tb;
   import igs_pkg::*;
   localparam int SW = 8;
   localparam int SH = 4;
   logic        clk_sys_i = 1'b0;
   logic        rstn_i    = 1'b0;
   logic        ce        = 1'b1;
   logic [3:0]  addr      = 4'h0;
   logic [31:0] wdata     = 32'h0;
   logic        wr_s      = 1'b0;
   logic        rd_s      = 1'b0;
   logic        go        = 1'b0;
   logic [31:0] rdata, oaddr;
   logic        pv, psof, ov, osof, oeol, oeof;
   logic [7:0]  pd, od;
   int          bad_count = 0;
   int          compares  = 0;
   int          cyc       = 0;
   int cs = 0, rs = 0, w = SW, h = SH, st = SW;
   int bh = 1, bv = 1, dh = 1, dv = 1, mlr = 0, mtb = 0;

   always #10 clk_sys_i = ~clk_sys_i;

   igs_geometry #(.SENSOR_W(SW), .SENSOR_H(SH), .PIX_W(8), .BPP(1))
   i_igs_geometry (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
      .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .pix_valid_i(pv), .pix_sof_i(psof), .pix_data_i(pd),
      .out_valid_o(ov), .out_sof_o(osof), .out_eol_o(oeol),
      .out_eof_o(oeof), .out_data_o(od), .out_addr_o(oaddr));

   igs_sensor_model #(.SW(SW), .SH(SH), .GAP(1)) i_igs_sensor_model (
      .clk_sys_i(clk_sys_i), .go_i(go), .pix_valid_o(pv),
      .pix_sof_o(psof), .pix_data_o(pd));

   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk_sys_i);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_sys_i);
      wr_s  <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdc(logic [3:0] a, logic [31:0] e);
      @(posedge clk_sys_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys_i);
      rd_s <= 1'b0;
      @(negedge clk_sys_i);
      chk($sformatf("register %h", a), rdata, e);
   endtask

   // expected pixel: crop origin, mirror in shrunk image, then bin sums
   function automatic logic [31:0] pix(int x, int y);
      int c, r, s;
      c = cs + x;
      r = rs + y;
      s = 0;
      if (mlr) c = SW / (bh * dh) - 1 - c;
      if (mtb) r = SH / (bv * dv) - 1 - r;
      for (int i = 0; i < bv; i++)
         for (int j = 0; j < bh; j++)
            s += (r * dv * bv + i) * SW + c * dh * bh + j;
      return (s > 255) ? 32'hff : 32'(s);
   endfunction

   // one frame; control is rewritten mid-fill and must not leak in
   task automatic frame(string nm, logic [31:0] nctl);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      wr(`IGS_REG_CTRL, nctl);
      rdc(`IGS_REG_STATUS, 32'h1);
      while (ov !== 1'b1 && n < 800) begin
         @(negedge clk_sys_i);
         n++;
      end
      for (int y = 0; y < h; y++)
         for (int x = 0; x < w; x++) begin
            chk("out_valid_o", ov, 1);
            chk("out_data_o", od, pix(x, y));
            chk("out_addr_o", oaddr, y * st + x);
            chk("out_eol_o", oeol, x == w - 1);
            chk("out_sof_o", osof, x == 0 && y == 0);
            chk("out_eof_o", oeof, x == w - 1 && y == h - 1);
            @(negedge clk_sys_i);
         end
      chk("out_valid_o idle", ov, 0);
      $display("test %s done", nm);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // the run needs well under 1500 cycles
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         end_of_test();
      end
   end

   // reset values, offset 0xe is unmapped; a write with ce low is lost
   task automatic t_reset();
      logic [31:0] rv [15];
      rv = '{32'h1, 32'h8, 32'h4, 32'h8, 32'h4, 32'h0, 32'h0, 32'h8,
             32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
      for (int a = 0; a < 15; a++)
         rdc(4'(a), rv[a]);
      wr(`IGS_REG_TAPS, 32'ha);
      rdc(`IGS_REG_TAPS, 32'ha);
      @(posedge clk_sys_i);
      ce <= 1'b0;
      wr(`IGS_REG_TAPS, 32'h5);
      ce <= 1'b1;
      rdc(`IGS_REG_TAPS, 32'ha);
      $display("test reset values done");
   endtask

   // crop window with both mirrors, stride a multiple of four bytes
   task automatic t_crop();
      mlr = 1;
      mtb = 1;
      wr(`IGS_REG_WIDTH, 32'h3);
      wr(`IGS_REG_HEIGHT, 32'h2);
      wr(`IGS_REG_COLSTART, 32'h1);
      wr(`IGS_REG_ROWSTART, 32'h1);
      wr(`IGS_REG_STRIDE, 32'h4);
      w = 3;
      h = 2;
      cs = 1;
      rs = 1;
      st = 4;
      frame("crop mirror", 32'h0);
   endtask

   // binning both ways, column subsample, refused width write
   task automatic t_shrink();
      mlr = 0;
      mtb = 0;
      wr(`IGS_REG_WIDTH, 32'h1);
      wr(`IGS_REG_HEIGHT, 32'h1);
      wr(`IGS_REG_COLSTART, 32'h0);
      wr(`IGS_REG_ROWSTART, 32'h0);
      wr(`IGS_REG_COLBIN, 32'h2);
      wr(`IGS_REG_COLSUB, 32'h2);
      wr(`IGS_REG_ROWBIN, 32'h2);
      rdc(`IGS_REG_MAXCOLS, 32'h2);
      rdc(`IGS_REG_MAXROWS, 32'h2);
      wr(`IGS_REG_WIDTH, 32'h3);
      rdc(`IGS_REG_WIDTH, 32'h1);
      rdc(`IGS_REG_STATUS, 32'h2);
      wr(`IGS_REG_STATUS, 32'h2);
      rdc(`IGS_REG_STATUS, 32'h0);
      wr(`IGS_REG_WIDTH, 32'h2);
      wr(`IGS_REG_HEIGHT, 32'h2);
      w = 2;
      h = 2;
      cs = 0;
      rs = 0;
      bh = 2;
      dh = 2;
      bv = 2;
      // control written mid-fill arms the left-right mirror for the next
      frame("shrink", 32'h1);
   endtask

   // row subsample alone, left-right mirror alone
   task automatic t_rowsub();
      mlr = 1;
      wr(`IGS_REG_COLBIN, 32'h1);
      wr(`IGS_REG_COLSUB, 32'h1);
      wr(`IGS_REG_ROWBIN, 32'h1);
      wr(`IGS_REG_ROWSUB, 32'h2);
      rdc(`IGS_REG_MAXCOLS, 32'h8);
      rdc(`IGS_REG_MAXROWS, 32'h2);
      bh = 1;
      dh = 1;
      bv = 1;
      dv = 2;
      frame("row subsample", 32'h0);
   endtask

   initial begin
      repeat (10) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      t_reset();
      frame("plain", 32'h3);
      t_crop();
      t_shrink();
      t_rowsub();
      end_of_test();
   end
endmodule // image_aoi_binning_decimation_flip_tb

// ===== inc/igs_pkg.sv
// types shared by the image geometry stage
package igs_pkg;
   typedef enum logic [1:0] {
      IGS_IDLE  = 2'b00,
      IGS_FILL  = 2'b01,
      IGS_DRAIN = 2'b10
   } igs_state_e;
   typedef logic [15:0] igs_dim_t;
   typedef logic [7:0]  igs_fac_t;
endpackage

// ===== inc/igs_regs.svh
// register offsets, field positions and reset values of the geometry stage
`ifndef IGS_REGS_SVH
`define IGS_REGS_SVH

// register offsets on the 4-bit register port
`define IGS_REG_TAPS     4'h0
`define IGS_REG_MAXCOLS  4'h1
`define IGS_REG_MAXROWS  4'h2
`define IGS_REG_WIDTH    4'h3
`define IGS_REG_HEIGHT   4'h4
`define IGS_REG_COLSTART 4'h5
`define IGS_REG_ROWSTART 4'h6
`define IGS_REG_STRIDE   4'h7
`define IGS_REG_COLBIN   4'h8
`define IGS_REG_ROWBIN   4'h9
`define IGS_REG_COLSUB   4'ha
`define IGS_REG_ROWSUB   4'hb
`define IGS_REG_CTRL     4'hc
`define IGS_REG_STATUS   4'hd

// field positions
`define IGS_CTRL_MIRROR_LR 0
`define IGS_CTRL_MIRROR_TB 1
`define IGS_STAT_BUSY      0
`define IGS_STAT_REFUSED   1

// reset values
`define IGS_RST_TAPS   4'h1
`define IGS_RST_FACTOR 8'h01
`define IGS_RST_START  16'h0000

`endif

// ===== rtl/igs_geometry.sv
// image geometry stage: binning, decimation, mirroring, crop and stride
`timescale 1ns/1ps
`include "igs_regs.svh"

module igs_geometry
   import igs_pkg::*;
#(
   parameter int SENSOR_W = 64,
   parameter int SENSOR_H = 48,
   parameter int PIX_W    = 8,
   parameter int BPP      = 1
) (
   // clock, reset, enable
   input  wire logic               clk_sys_i,
   input  wire logic               rstn_i,
   input  wire logic               ce_i,
   // register port
   input  wire logic [3:0]         reg_addr_i,
   input  wire logic [31:0]        reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic      [31:0]        reg_rdata_o,
   // sensor pixel stream
   input  wire logic               pix_valid_i,
   input  wire logic               pix_sof_i,
   input  wire logic [PIX_W-1:0]   pix_data_i,
   // output pixel stream
   output logic                    out_valid_o,
   output logic                    out_sof_o,
   output logic                    out_eol_o,
   output logic                    out_eof_o,
   output logic      [PIX_W-1:0]   out_data_o,
   output logic      [31:0]        out_addr_o
);
   localparam int AW = $clog2(SENSOR_W * SENSOR_H);

   // subsample factor zero is taken as one so a cleared subsample factor never divides by zero
   function automatic igs_fac_t f_eff(input igs_fac_t d);
      return (d == 8'h00) ? 8'h01 : d;
   endfunction

   function automatic igs_dim_t f_max(input igs_dim_t n, input igs_fac_t b,
                                      input igs_fac_t d);
      igs_dim_t p;
      p = {8'h00, b} * {8'h00, f_eff(d)};
      return (p == 16'h0000) ? 16'h0000 : n / p;
   endfunction

   function automatic logic f_ok(input igs_dim_t w, input igs_dim_t h,
                                 input igs_dim_t ox, input igs_dim_t oy,
                                 input igs_fac_t bh, input igs_fac_t bv,
                                 input igs_fac_t dh, input igs_fac_t dv);
      logic [16:0] ex;
      logic [16:0] ey;
      ex = {1'b0, ox} + {1'b0, w};
      ey = {1'b0, oy} + {1'b0, h};
      return (w != 16'h0000) && (h != 16'h0000) && (bh != 8'h00) &&
             (bv != 8'h00) &&
             (ex <= {1'b0, f_max(16'(SENSOR_W), bh, dh)}) &&
             (ey <= {1'b0, f_max(16'(SENSOR_H), bv, dv)});
   endfunction

   function automatic logic [PIX_W-1:0] f_sat(input logic [PIX_W-1:0] a,
                                              input logic [PIX_W-1:0] b);
      logic [PIX_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[PIX_W] ? {PIX_W{1'b1}} : s[PIX_W-1:0];
   endfunction

   function automatic logic [AW-1:0] f_idx(input igs_dim_t r,
                                           input igs_dim_t c);
      return AW'(32'(r) * 32'(SENSOR_W) + 32'(c));
   endfunction

   // software-visible registers
   logic [3:0]  taps_ff;
   igs_dim_t    width_ff, height_ff, colst_ff, rowst_ff, stride_ff;
   igs_fac_t    colbin_ff, rowbin_ff, colsub_ff, rowsub_ff;
   logic [1:0]  ctrl_ff;
   logic        refused_ff;
   igs_dim_t    maxc_ff, maxr_ff;
   igs_state_e  state_ff;

   // candidate register set as it would stand after this write
   igs_dim_t c_w, c_h, c_ox, c_oy;
   igs_fac_t c_bh, c_bv, c_dh, c_dv;
   logic     geo_wr, wr_ok;
   always_comb begin
      c_w  = width_ff;
      c_h  = height_ff;
      c_ox = colst_ff;
      c_oy = rowst_ff;
      c_bh = colbin_ff;
      c_bv = rowbin_ff;
      c_dh = colsub_ff;
      c_dv = rowsub_ff;
      geo_wr = 1'b1;
      unique case (reg_addr_i)
         `IGS_REG_WIDTH:    c_w  = reg_wdata_i[15:0];
         `IGS_REG_HEIGHT:   c_h  = reg_wdata_i[15:0];
         `IGS_REG_COLSTART: c_ox = reg_wdata_i[15:0];
         `IGS_REG_ROWSTART: c_oy = reg_wdata_i[15:0];
         `IGS_REG_COLBIN:   c_bh = reg_wdata_i[7:0];
         `IGS_REG_ROWBIN:   c_bv = reg_wdata_i[7:0];
         `IGS_REG_COLSUB:   c_dh = reg_wdata_i[7:0];
         `IGS_REG_ROWSUB:   c_dv = reg_wdata_i[7:0];
         default:           geo_wr = 1'b0;
      endcase
      wr_ok = f_ok(c_w, c_h, c_ox, c_oy, c_bh, c_bv, c_dh, c_dv);
   end

   // register writes; a geometry write breaking the crop bounds is dropped
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         taps_ff   <= `IGS_RST_TAPS;
         width_ff  <= 16'(SENSOR_W);
         height_ff <= 16'(SENSOR_H);
         colst_ff  <= `IGS_RST_START;
         rowst_ff  <= `IGS_RST_START;
         stride_ff <= 16'(SENSOR_W * BPP);
         colbin_ff <= `IGS_RST_FACTOR;
         rowbin_ff <= `IGS_RST_FACTOR;
         colsub_ff <= `IGS_RST_FACTOR;
         rowsub_ff <= `IGS_RST_FACTOR;
         ctrl_ff   <= 2'b00;
      end else if (ce_i && reg_wr_i) begin
         if (reg_addr_i == `IGS_REG_TAPS)
            taps_ff <= reg_wdata_i[3:0];
         if (reg_addr_i == `IGS_REG_STRIDE)
            stride_ff <= reg_wdata_i[15:0];
         if (reg_addr_i == `IGS_REG_CTRL)
            ctrl_ff <= reg_wdata_i[1:0];
         if (geo_wr && wr_ok) begin
            width_ff  <= c_w;
            height_ff <= c_h;
            colst_ff  <= c_ox;
            rowst_ff  <= c_oy;
            colbin_ff <= c_bh;
            rowbin_ff <= c_bv;
            colsub_ff <= c_dh;
            rowsub_ff <= c_dv;
         end
      end
   end

   // sticky refusal flag, write one to clear; a new refusal wins the clear
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         refused_ff <= 1'b0;
      end else if (ce_i) begin
         if (reg_wr_i && geo_wr && !wr_ok)
            refused_ff <= 1'b1;
         else if (reg_wr_i && reg_addr_i == `IGS_REG_STATUS &&
                  reg_wdata_i[`IGS_STAT_REFUSED])
            refused_ff <= 1'b0;
      end
   end

   // shrunk image size follows the live factors
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         maxc_ff <= 16'(SENSOR_W);
         maxr_ff <= 16'(SENSOR_H);
      end else if (ce_i) begin
         maxc_ff <= f_max(16'(SENSOR_W), colbin_ff, colsub_ff);
         maxr_ff <= f_max(16'(SENSOR_H), rowbin_ff, rowsub_ff);
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         reg_rdata_o <= 32'h0000_0000;
         if (reg_rd_i) begin
            unique case (reg_addr_i)
               `IGS_REG_TAPS:     reg_rdata_o <= 32'(taps_ff);
               `IGS_REG_MAXCOLS:  reg_rdata_o <= 32'(maxc_ff);
               `IGS_REG_MAXROWS:  reg_rdata_o <= 32'(maxr_ff);
               `IGS_REG_WIDTH:    reg_rdata_o <= 32'(width_ff);
               `IGS_REG_HEIGHT:   reg_rdata_o <= 32'(height_ff);
               `IGS_REG_COLSTART: reg_rdata_o <= 32'(colst_ff);
               `IGS_REG_ROWSTART: reg_rdata_o <= 32'(rowst_ff);
               `IGS_REG_STRIDE:   reg_rdata_o <= 32'(stride_ff);
               `IGS_REG_COLBIN:   reg_rdata_o <= 32'(colbin_ff);
               `IGS_REG_ROWBIN:   reg_rdata_o <= 32'(rowbin_ff);
               `IGS_REG_COLSUB:   reg_rdata_o <= 32'(colsub_ff);
               `IGS_REG_ROWSUB:   reg_rdata_o <= 32'(rowsub_ff);
               `IGS_REG_CTRL:     reg_rdata_o <= 32'(ctrl_ff);
               `IGS_REG_STATUS:   reg_rdata_o <= {30'h0, refused_ff,
                                                  state_ff != IGS_IDLE};
               default:           reg_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // frame shadows: taken at start of frame, held through fill and drain
   igs_dim_t sh_w, sh_h, sh_ox, sh_oy, sh_stride, sh_maxc, sh_maxr;
   igs_fac_t sh_bh, sh_bv, sh_dh, sh_dv;
   logic     sh_mlr, sh_mtb;
   logic     frame_go;
   assign frame_go = (state_ff == IGS_IDLE) && pix_valid_i && pix_sof_i;
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         sh_w <= 16'h0001;  sh_h <= 16'h0001;
         sh_ox <= 16'h0000; sh_oy <= 16'h0000;
         sh_stride <= 16'h0000;
         sh_maxc <= 16'h0001; sh_maxr <= 16'h0001;
         sh_bh <= 8'h01; sh_bv <= 8'h01; sh_dh <= 8'h01; sh_dv <= 8'h01;
         sh_mlr <= 1'b0; sh_mtb <= 1'b0;
      end else if (ce_i && frame_go) begin
         sh_w <= width_ff;  sh_h <= height_ff;
         sh_ox <= colst_ff; sh_oy <= rowst_ff;
         sh_stride <= stride_ff;
         sh_maxc <= f_max(16'(SENSOR_W), colbin_ff, colsub_ff);
         sh_maxr <= f_max(16'(SENSOR_H), rowbin_ff, rowsub_ff);
         sh_bh <= colbin_ff; sh_bv <= rowbin_ff;
         sh_dh <= f_eff(colsub_ff); sh_dv <= f_eff(rowsub_ff);
         sh_mlr <= ctrl_ff[`IGS_CTRL_MIRROR_LR];
         sh_mtb <= ctrl_ff[`IGS_CTRL_MIRROR_TB];
      end
   end

   // one input stage; frames arriving while busy are dropped whole
   logic             p_valid_ff;
   logic [PIX_W-1:0] p_data_ff;
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         p_valid_ff <= 1'b0;
         p_data_ff  <= '0;
      end else if (ce_i) begin
         p_valid_ff <= pix_valid_i && (frame_go || state_ff == IGS_FILL);
         p_data_ff  <= pix_data_i;
      end
   end

   // shrunk frame store
   logic [PIX_W-1:0] mem [SENSOR_W*SENSOR_H];

   // fill counters
   igs_dim_t sx_ff, sy_ff, cx_ff, cy_ff, ox_ff, oy_ff;
   igs_fac_t hb_ff, vb_ff, hd_ff, vd_ff;
   logic [PIX_W-1:0] acc_ff;
   logic [31:0] lbase_ff, cbyte_ff;

   logic             fill_pix, g_end, col_keep, row_keep, do_wr;
   logic             line_end, frame_end, out_last;
   logic [PIX_W-1:0] sum, wval;
   logic [AW-1:0]    widx, ridx;
   igs_dim_t         rcol, rrow;
   assign fill_pix  = ce_i && p_valid_ff && state_ff == IGS_FILL;
   assign g_end     = hb_ff == sh_bh - 8'h01;
   assign sum       = f_sat((hb_ff == 8'h00) ? '0 : acc_ff, p_data_ff);
   assign col_keep  = hd_ff == 8'h00 && cx_ff < sh_maxc;
   assign row_keep  = vd_ff == 8'h00 && cy_ff < sh_maxr;
   assign do_wr     = fill_pix && g_end && col_keep && row_keep;
   assign widx      = f_idx(cy_ff, cx_ff);
   assign wval      = (vb_ff == 8'h00) ? sum : f_sat(mem[widx], sum);
   assign line_end  = sx_ff == 16'(SENSOR_W - 1);
   assign frame_end = line_end && sy_ff == 16'(SENSOR_H - 1);

   // binned pixel is written once per sensor row of a kept group; factor one writes each
   always_ff @(posedge clk_sys_i) begin
      if (do_wr)
         mem[widx] <= wval;
   end

   // raster walk of the sensor frame through bin and subsample counters
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         sx_ff <= '0; sy_ff <= '0; cx_ff <= '0; cy_ff <= '0;
         hb_ff <= '0; vb_ff <= '0; hd_ff <= '0; vd_ff <= '0;
         acc_ff <= '0;
      end else if (ce_i && frame_go) begin
         sx_ff <= '0; sy_ff <= '0; cx_ff <= '0; cy_ff <= '0;
         hb_ff <= '0; vb_ff <= '0; hd_ff <= '0; vd_ff <= '0;
      end else if (fill_pix) begin
         acc_ff <= sum;
         if (g_end) begin
            hb_ff <= '0;
            hd_ff <= (hd_ff == sh_dh - 8'h01) ? 8'h00 : hd_ff + 8'h01;
            if (col_keep)
               cx_ff <= cx_ff + 16'h0001;
         end else begin
            hb_ff <= hb_ff + 8'h01;
         end
         sx_ff <= sx_ff + 16'h0001;
         // partial groups at a line end are discarded
         if (line_end) begin
            sx_ff <= '0; cx_ff <= '0; hb_ff <= '0; hd_ff <= '0;
            sy_ff <= sy_ff + 16'h0001;
            if (vb_ff == sh_bv - 8'h01) begin
               vb_ff <= '0;
               vd_ff <= (vd_ff == sh_dv - 8'h01) ? 8'h00 : vd_ff + 8'h01;
               if (row_keep)
                  cy_ff <= cy_ff + 16'h0001;
            end else begin
               vb_ff <= vb_ff + 8'h01;
            end
         end
      end
   end

   // offset, then mirror in shrunk coordinates: crop sees the flipped image
   always_comb begin
      rcol = ox_ff + sh_ox;
      rrow = oy_ff + sh_oy;
      if (sh_mlr)
         rcol = sh_maxc - 16'h0001 - rcol;
      if (sh_mtb)
         rrow = sh_maxr - 16'h0001 - rrow;
      ridx = f_idx(rrow, rcol);
   end
   assign out_last = ox_ff == sh_w - 16'h0001 && oy_ff == sh_h - 16'h0001;

   // frame sequencing
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         state_ff <= IGS_IDLE;
      end else if (ce_i) begin
         unique case (state_ff)
            IGS_IDLE:  if (frame_go) state_ff <= IGS_FILL;
            IGS_FILL:  if (fill_pix && frame_end) state_ff <= IGS_DRAIN;
            IGS_DRAIN: if (out_last) state_ff <= IGS_IDLE;
            default:   state_ff <= IGS_IDLE;
         endcase
      end
   end

   // drain walks the crop window, one pixel a cycle, no back-pressure
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ox_ff <= '0; oy_ff <= '0;
         lbase_ff <= '0; cbyte_ff <= '0;
      end else if (ce_i && state_ff == IGS_DRAIN) begin
         if (ox_ff == sh_w - 16'h0001) begin
            ox_ff    <= '0;
            cbyte_ff <= '0;
            oy_ff    <= out_last ? 16'h0000 : oy_ff + 16'h0001;
            lbase_ff <= out_last ? 32'h0 : lbase_ff + 32'(sh_stride);
         end else begin
            ox_ff    <= ox_ff + 16'h0001;
            cbyte_ff <= cbyte_ff + 32'(BPP);
         end
      end
   end

   // output stage
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         out_valid_o <= 1'b0;
         out_sof_o   <= 1'b0;
         out_eol_o   <= 1'b0;
         out_eof_o   <= 1'b0;
         out_data_o  <= '0;
         out_addr_o  <= '0;
      end else if (ce_i) begin
         out_valid_o <= state_ff == IGS_DRAIN;
         out_sof_o   <= state_ff == IGS_DRAIN && ox_ff == 16'h0 &&
                        oy_ff == 16'h0;
         out_eol_o   <= state_ff == IGS_DRAIN && ox_ff == sh_w - 16'h0001;
         out_eof_o   <= state_ff == IGS_DRAIN && out_last;
         out_data_o  <= mem[ridx];
         out_addr_o  <= lbase_ff + cbyte_ff;
      end
   end

   // helper counters for the checks below
   igs_dim_t a_col_ff, a_row_ff;
   logic [31:0] a_lst_ff;
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         a_col_ff <= '0; a_row_ff <= '0; a_lst_ff <= '0;
      end else if (ce_i && out_valid_o) begin
         a_col_ff <= out_eol_o ? 16'h0 : a_col_ff + 16'h0001;
         a_row_ff <= out_eof_o ? 16'h0 :
                     (out_eol_o ? a_row_ff + 16'h0001 : a_row_ff);
         if (a_col_ff == 16'h0)
            a_lst_ff <= out_addr_o;
      end
   end

   AST_LINE_WIDTH: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) out_valid_o && out_eol_o |-> a_col_ff == sh_w - 1)
      else $error("output line length differs from width");
   AST_FRAME_HEIGHT: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) out_valid_o && out_eof_o |-> a_row_ff == sh_h - 1)
      else $error("output frame height differs from height");
   AST_LINE_STRIDE: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      out_valid_o && !out_sof_o && a_col_ff == 16'h0 && ce_i
      |-> out_addr_o == a_lst_ff + 32'(sh_stride))
      else $error("line start not one stride after previous");
   AST_SOF_ORIGIN: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) out_valid_o && out_sof_o |-> out_addr_o == 0)
      else $error("frame does not start at byte zero");
   AST_REFUSE_KEEP: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) ce_i && reg_wr_i && geo_wr && !wr_ok
      |=> $stable(width_ff) && $stable(colst_ff) && refused_ff)
      else $error("refused geometry write changed a register");
   AST_SHADOW_HOLD: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) state_ff != IGS_IDLE && $past(state_ff) != IGS_IDLE
      |-> $stable(sh_w) && $stable(sh_ox) && $stable(sh_bh))
      else $error("geometry changed inside a frame");
   AST_MAX_COLS: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) maxc_ff != 16'h0 && maxc_ff >= colst_ff + width_ff)
      else $error("maximum columns zero or below crop end");
   AST_MAX_ROWS: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) maxr_ff != 16'h0 && maxr_ff >= rowst_ff + height_ff)
      else $error("maximum rows zero or below crop end");
   AST_NO_SHRINK: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) state_ff == IGS_DRAIN && sh_bh == 8'h01 &&
      sh_dh == 8'h01 |-> sh_maxc == 16'(SENSOR_W))
      else $error("unit factors changed the column count");
   AST_MIRROR_LR: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) state_ff == IGS_DRAIN && sh_mlr
      |-> rcol < sh_maxc && rcol + ox_ff + sh_ox == sh_maxc - 16'h0001)
      else $error("left-right mirror column wrong");

   COV_MIRROR_FRAME: cover property (@(posedge clk_sys_i)
      out_eof_o && sh_mlr && sh_mtb);
   COV_BIN_FRAME: cover property (@(posedge clk_sys_i)
      out_eof_o && sh_bh == 8'h02 && sh_bv == 8'h02);
   COV_SUB_FRAME: cover property (@(posedge clk_sys_i)
      out_eof_o && sh_dh == 8'h02);
   COV_REFUSED: cover property (@(posedge clk_sys_i)
      reg_wr_i && geo_wr && !wr_ok);

endmodule // igs_geometry
